// [src/ahs_host_seq.sv]
// top of the host-side sequencer; strobes are active low and sampled on clk
// assumes the host bus signals are synchronous to the converter clock
`timescale 1ns/100ps
module ahs_host_seq
	import ahs_pkg::*;
#(
	parameter int RES_BITS = AHS_RES_BITS
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic csB,
	input wire logic rdB,
	input wire logic wrB,
	input wire logic cdSel,
	input wire logic [1:0] modeSel,
	input wire logic standAlone,
	input wire logic twosComp,
	input wire logic compHigh,
	output logic [AHS_LOWER_BITS-1:0] dataOut,
	output logic dataOe,
	output logic ackOut,
	output logic ackOe,
	output logic convRunningInt,
	output logic [RES_BITS-1:0] dacCode,
	output logic upperValid,
	output logic lowerValid
);

	// previous strobe levels for edge detection
	logic csQ;
	logic rdQ;
	logic wrQ;
	logic wrSelQ;

	// read-started mode bookkeeping
	ahs_phase_t phase_q;
	ahs_phase_t phase_d;
	logic freshQ;
	logic [AHS_UPPER_BITS-1:0] msbLatchQ;

	// ack and data output registers
	logic ackBusyQ;
	logic ackBusyD;
	logic [AHS_LOWER_BITS-1:0] dataQ;
	logic dataOeQ;

	// decoded modes and strobe events
	logic modeRd;
	logic modeWr;
	logic sel;
	logic csFall;
	logic csRise;
	logic rdRise;
	logic wrRise;
	logic rdStart;
	logic wrStart;
	logic saStart;
	logic startConv;

	// core outputs
	logic convRunning;
	logic convDone;
	logic [AHS_CNT_BITS-1:0] elapsed;
	logic [RES_BITS-1:0] trialCode;
	logic [RES_BITS-1:0] resultCode;

	// byte path
	logic [RES_BITS-1:0] liveCode;
	logic [RES_BITS-1:0] muxCode;
	logic selUpper;
	logic [AHS_LOWER_BITS-1:0] muxByte;
	logic upperOk;
	logic [AHS_CNT_BITS-1:0] upperCyc;

	// mode decode; stand-alone overrides whatever mode is selected
	assign modeRd = !standAlone && (modeSel == AHS_MODE_RD_START);
	assign modeWr = !standAlone && (modeSel == AHS_MODE_WR_UNGATED);
	assign sel = !csB;

	// strobe history
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			csQ <= 1'b1;
			rdQ <= 1'b1;
			wrQ <= 1'b1;
		end else begin
			csQ <= csB;
			rdQ <= rdB;
			wrQ <= wrB;
		end
	end

	// edges seen this cycle
	assign csFall = csQ && !csB;
	assign csRise = !csQ && csB;
	assign rdRise = !rdQ && rdB;
	assign wrRise = !wrQ && wrB;

	// remembers that the write now ending was issued while selected
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wrSelQ <= 1'b0;
		end else if (!wrB) begin
			wrSelQ <= sel;
		end else if (wrRise) begin
			wrSelQ <= 1'b0;
		end
	end

	// read-started mode: cs opens the burst, a low read ending relaunches
	always_comb begin
		phase_d = phase_q;
		rdStart = 1'b0;
		if (!modeRd) begin
			phase_d = AHS_PH_IDLE;
		end else begin
			case (phase_q)
				AHS_PH_IDLE: begin
					if (csFall) begin
						rdStart = 1'b1;
						phase_d = AHS_PH_LOW;
					end
				end
				AHS_PH_LOW: begin
					if (rdRise && sel) begin
						rdStart = 1'b1;
						phase_d = AHS_PH_HIGH;
					end
				end
				AHS_PH_HIGH: begin
					// upper read relaunches nothing; cs high ends the burst
					if (csRise) begin
						phase_d = AHS_PH_IDLE;
					end else if (rdRise && sel) begin
						phase_d = AHS_PH_LOW;
					end
				end
				default: begin
					phase_d = AHS_PH_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_q <= AHS_PH_IDLE;
		end else begin
			phase_q <= phase_d;
		end
	end

	// write-started and stand-alone launches on the rising write strobe
	assign wrStart = modeWr && wrRise && wrSelQ;
	assign saStart = standAlone && wrRise;
	assign startConv = (rdStart || wrStart || saStart) && !convRunning;

	ahs_sar_core #(
		.RES_BITS(RES_BITS)
	) u_core (
		.clk(clk),
		.rst_b(rst_b),
		.startConv(startConv),
		.compHigh(compHigh),
		.convRunning(convRunning),
		.convDone(convDone),
		.elapsed(elapsed),
		.trialCode(trialCode),
		.resultCode(resultCode)
	);

	// upper nibble of the finished code is kept for the following upper read
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			msbLatchQ <= '0;
		end else if (rdStart && !convRunning) begin
			msbLatchQ <= resultCode[RES_BITS-1 -: AHS_UPPER_BITS];
		end
	end

	// fresh result waiting for its low read; a done in the clearing cycle wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			freshQ <= 1'b0;
		end else if (convDone) begin
			freshQ <= 1'b1;
		end else if (startConv || (modeRd && phase_q == AHS_PH_LOW && rdRise)) begin
			freshQ <= 1'b0;
		end
	end

	// busy level per mode; gated modes release ack while deselected
	always_comb begin
		ackBusyD = 1'b1;
		if (modeRd) begin
			if (!sel) begin
				ackBusyD = 1'b1;
			end else if (phase_q == AHS_PH_HIGH) begin
				ackBusyD = 1'b0;
			end else if (convRunning || startConv) begin
				ackBusyD = 1'b1;
			end else if (!rdB && !freshQ) begin
				ackBusyD = 1'b1;
			end else begin
				ackBusyD = 1'b0;
			end
		end else if (modeWr || standAlone) begin
			// ungated: follows the converter at all times
			ackBusyD = convRunning || startConv;
		end
	end

	// one register stage gives the one-period ack delay
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ackBusyQ <= 1'b1;
		end else begin
			ackBusyQ <= ackBusyD;
		end
	end

	// open collector: pull low only when complete
	assign ackOut = 1'b0;
	assign ackOe = !ackBusyQ;

	// upper nibble settles earlier in stand-alone mode
	assign upperCyc = standAlone ? AHS_SA_UB_CYC : AHS_MSB_VALID_CYC;
	assign upperOk = !convRunning || (elapsed >= upperCyc);

	// live trial code stands in for the result while converting
	assign liveCode = convRunning ? trialCode : resultCode;

	// read-started mode picks the byte itself; other modes use cd select
	always_comb begin
		muxCode = liveCode;
		selUpper = cdSel;
		if (modeRd) begin
			selUpper = (phase_q == AHS_PH_HIGH);
			if (phase_q == AHS_PH_HIGH) begin
				muxCode[RES_BITS-1 -: AHS_UPPER_BITS] = msbLatchQ;
			end
		end
	end

	ahs_byte_mux u_mux (
		.code(muxCode),
		.twosComp(twosComp && !standAlone),
		.selUpper(selUpper),
		.dataByte(muxByte)
	);

	// data bus drives only during a selected read; stand-alone reads too
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dataQ <= '0;
			dataOeQ <= 1'b0;
		end else begin
			dataQ <= muxByte;
			dataOeQ <= sel && !rdB;
		end
	end

	assign dataOut = dataQ;
	assign dataOe = dataOeQ;
	assign convRunningInt = convRunning;
	assign dacCode = trialCode;
	assign upperValid = upperOk;
	assign lowerValid = !convRunning && !startConv;

endmodule : ahs_host_seq

// [src/ahs_pkg.sv]
// constants and types shared by the converter sequencer files
// assumes one 20 MHz converter clock drives every file
package ahs_pkg;

	// clock rate and the timing figures derived from it
	localparam int AHS_CLK_PERIOD_NS = 50;
	localparam int AHS_ACK_DLY_NS = 50;
	localparam int AHS_ACK_DLY_CYC = (AHS_ACK_DLY_NS + AHS_CLK_PERIOD_NS - 1) / AHS_CLK_PERIOD_NS;

	// result layout
	localparam int AHS_RES_BITS = 12;
	localparam int AHS_UPPER_BITS = 4;
	localparam int AHS_LOWER_BITS = 8;
	localparam int AHS_CNT_BITS = 4;

	// conversion length and upper-nibble settle times, in clock periods
	localparam logic [AHS_CNT_BITS-1:0] AHS_CONV_CYC = 4'hC;
	localparam logic [AHS_CNT_BITS-1:0] AHS_MSB_VALID_CYC = 4'h6;
	// stand-alone upper byte: four and a half periods, rounded up
	localparam int AHS_SA_UB_HALF_CYC = 9;
	localparam logic [AHS_CNT_BITS-1:0] AHS_SA_UB_CYC = AHS_CNT_BITS'((AHS_SA_UB_HALF_CYC + 1) / 2);

	// operating mode codes on the mode select input
	localparam logic [1:0] AHS_MODE_RD_START = 2'h2;
	localparam logic [1:0] AHS_MODE_WR_UNGATED = 2'h3;

	// read-started mode: which byte the next read returns
	typedef enum logic [1:0] {
		AHS_PH_IDLE = 2'h0,
		AHS_PH_LOW = 2'h1,
		AHS_PH_HIGH = 2'h3
	} ahs_phase_t;

endpackage : ahs_pkg

// [src/ahs_sar_core.sv]
// successive-approximation engine: one bit decided per clock
// assumes the analog comparator answer is settled each clock edge
`timescale 1ns/100ps
module ahs_sar_core
	import ahs_pkg::*;
#(
	parameter int RES_BITS = AHS_RES_BITS
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic startConv,
	input wire logic compHigh,
	output logic convRunning,
	output logic convDone,
	output logic [AHS_CNT_BITS-1:0] elapsed,
	output logic [RES_BITS-1:0] trialCode,
	output logic [RES_BITS-1:0] resultCode
);

	logic runQ;
	logic doneQ;
	logic [AHS_CNT_BITS-1:0] cntQ;
	logic [RES_BITS-1:0] maskQ;
	logic [RES_BITS-1:0] trialQ;
	logic [RES_BITS-1:0] resQ;

	// run flag and elapsed count; a start while busy is dropped
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			runQ <= 1'b0;
			cntQ <= '0;
		end else if (startConv && !runQ) begin
			runQ <= 1'b1;
			cntQ <= '0;
		end else if (runQ) begin
			cntQ <= cntQ + 1'b1;
			if (cntQ == AHS_CONV_CYC - 1'b1) begin
				runQ <= 1'b0;
			end
		end
	end

	// trial bit walks from msb to lsb, kept when the comparator says so
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			maskQ <= '0;
			trialQ <= '0;
		end else if (startConv && !runQ) begin
			maskQ <= {1'b1, {(RES_BITS-1){1'b0}}};
			trialQ <= {1'b1, {(RES_BITS-1){1'b0}}};
		end else if (runQ) begin
			maskQ <= maskQ >> 1;
			trialQ <= (compHigh ? trialQ : (trialQ & ~maskQ)) | (maskQ >> 1);
		end
	end

	// finished code and a one-cycle done pulse
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			resQ <= '0;
			doneQ <= 1'b0;
		end else begin
			doneQ <= runQ && maskQ[0];
			if (runQ && maskQ[0]) begin
				resQ <= compHigh ? trialQ : (trialQ & ~maskQ);
			end
		end
	end

	assign convRunning = runQ;
	assign convDone = doneQ;
	assign elapsed = cntQ;
	assign trialCode = trialQ;
	assign resultCode = resQ;

endmodule : ahs_sar_core

// [src/ahs_byte_mux.sv]
// output code and byte selection for the shared data outputs
// assumes the caller registers the byte before it reaches the pins
`timescale 1ns/100ps
module ahs_byte_mux
	import ahs_pkg::*;
(
	input wire logic [AHS_RES_BITS-1:0] code,
	input wire logic twosComp,
	input wire logic selUpper,
	output logic [AHS_LOWER_BITS-1:0] dataByte
);

	logic [AHS_RES_BITS-1:0] outCode;

	// two's complement differs from offset binary only in the msb
	always_comb begin
		outCode = code;
		outCode[AHS_RES_BITS-1] = code[AHS_RES_BITS-1] ^ twosComp;
		if (selUpper) begin
			dataByte = {{(AHS_LOWER_BITS-AHS_UPPER_BITS){1'b0}},
				outCode[AHS_RES_BITS-1 -: AHS_UPPER_BITS]};
		end else begin
			dataByte = outCode[AHS_LOWER_BITS-1:0];
		end
	end

endmodule : ahs_byte_mux

// [tb/ahs_comp_model.sv]
// comparator side of the converter, a fixed analog level as a code
// assumes dacCode is the registered trial code of the sequencer
`timescale 1ns/100ps
module ahs_comp_model
	import ahs_pkg::*;
(
	input wire logic [AHS_RES_BITS-1:0] dacCode,
	input wire logic [AHS_RES_BITS-1:0] target,
	output logic compHigh
);
	// keep the trial bit while the trial stays at or below the input
	assign compHigh = (dacCode <= target);
endmodule : ahs_comp_model

// [tb/ahs_host_seq_props.sv]
// assertions on the top ports of the host sequencer
// assumes bind onto ahs_host_seq, single clock domain
`timescale 1ns/100ps
module ahs_host_seq_props
	import ahs_pkg::*;
#(
	parameter int RES_BITS = AHS_RES_BITS
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic csB,
	input wire logic rdB,
	input wire logic wrB,
	input wire logic cdSel,
	input wire logic [1:0] modeSel,
	input wire logic standAlone,
	input wire logic twosComp,
	input wire logic compHigh,
	input wire logic [AHS_LOWER_BITS-1:0] dataOut,
	input wire logic dataOe,
	input wire logic ackOut,
	input wire logic ackOe,
	input wire logic convRunningInt,
	input wire logic [RES_BITS-1:0] dacCode,
	input wire logic upperValid,
	input wire logic lowerValid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic m2;
	logic m3;
	// mode decodes, stand-alone overrides the select code
	assign m2 = !standAlone && modeSel == AHS_MODE_RD_START;
	assign m3 = !standAlone && modeSel == AHS_MODE_WR_UNGATED;

	a_conv_len: assert property ($rose(convRunningInt) |-> ##11 convRunningInt ##1 !convRunningInt)
		else $error("conversion length wrong");
	a_wr_start: assert property (m3 && wrB && !$past(wrB) && !$past(csB) && !convRunningInt |=> convRunningInt)
		else $error("write did not start conversion");
	a_ack_busy: assert property (m3 && convRunningInt && $past(convRunningInt) |-> !ackOe)
		else $error("ack not busy while running");
	a_ack_done: assert property (m3 && $fell(convRunningInt) |=> ackOe)
		else $error("ack not complete after conversion");
	a_rd_busy: assert property (m2 && !csB && $rose(convRunningInt) |-> ##[0:1] !ackOe)
		else $error("ack not busy in read mode");
	a_low_valid: assert property (lowerValid |-> !convRunningInt)
		else $error("low byte valid while running");
	a_nib_six: assert property ($rose(convRunningInt) |-> ##6 upperValid)
		else $error("upper nibble late");
	a_upper_pad: assert property (m3 && !csB && !rdB && cdSel |=> dataOe && dataOut[7:4] == 4'h0)
		else $error("upper byte not padded");
	a_sa_busy: assert property (standAlone && wrB && !$past(wrB) && !convRunningInt |=> ##[0:1] !ackOe)
		else $error("stand-alone ack not busy");

	// main scenarios reached
	c_rd_conv: cover property (m2 && $rose(convRunningInt));
	c_wr_done: cover property (m3 && $fell(convRunningInt));
	c_sa_conv: cover property (standAlone && $rose(convRunningInt));
endmodule : ahs_host_seq_props

bind ahs_host_seq ahs_host_seq_props #(.RES_BITS(RES_BITS)) u_props (
	.clk(clk), .rst_b(rst_b), .csB(csB), .rdB(rdB), .wrB(wrB), .cdSel(cdSel),
	.modeSel(modeSel), .standAlone(standAlone), .twosComp(twosComp), .compHigh(compHigh),
	.dataOut(dataOut), .dataOe(dataOe), .ackOut(ackOut), .ackOe(ackOe),
	.convRunningInt(convRunningInt), .dacCode(dacCode), .upperValid(upperValid), .lowerValid(lowerValid)
);

// [tb/adc_host_mode_sequencer_tb.sv]
// scenario bench for the host sequencer in write, read and stand-alone modes
// assumes the comparator model and the bound checker are compiled alongside
`timescale 1ns/100ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin failures++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, a); end end
module adc_host_mode_sequencer_tb
	import ahs_pkg::*;
;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic csB = 1'b1;
	logic rdB = 1'b1;
	logic wrB = 1'b1;
	logic cdSel = 1'b0;
	logic [1:0] modeSel = 2'h0;
	logic standAlone = 1'b0;
	logic twosComp = 1'b0;
	logic compHigh;
	logic [7:0] dataOut;
	logic dataOe;
	logic ackOut;
	logic ackOe;
	logic convRunningInt;
	logic [11:0] dacCode;
	logic upperValid;
	logic lowerValid;
	logic [11:0] target = 12'h000;
	int failures = 0;
	int n_checks = 0;

	// 20 MHz converter clock
	always #25 clk = ~clk;

	ahs_host_seq DUT (.clk(clk), .rst_b(rst_b), .csB(csB), .rdB(rdB), .wrB(wrB), .cdSel(cdSel),
		.modeSel(modeSel), .standAlone(standAlone), .twosComp(twosComp), .compHigh(compHigh),
		.dataOut(dataOut), .dataOe(dataOe), .ackOut(ackOut), .ackOe(ackOe),
		.convRunningInt(convRunningInt), .dacCode(dacCode), .upperValid(upperValid), .lowerValid(lowerValid));
	ahs_comp_model u_comp (.dacCode(dacCode), .target(target), .compHigh(compHigh));

	task automatic close_out;
		if (failures == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : close_out

	// bounded wait on ack (s=1) or the conversion line (s=0)
	task automatic wt(input bit s, input logic v);
		int i;
		for (i = 0; i < 40 && (s ? ackOe : convRunningInt) !== v; i++) @(negedge clk);
		if (i == 40) begin
			failures++;
			close_out();
		end
	endtask : wt

	// selected read; data lands on the first rising edge after the strobe is driven
	task automatic rd(input logic cd, input logic [7:0] e, input logic ea);
		@(posedge clk);
		csB <= 1'b0;
		cdSel <= cd;
		rdB <= 1'b0;
		repeat (3) @(negedge clk);
		`CHK("read data", e, dataOut)
		`CHK("read oe", 1'b1, dataOe)
		`CHK("read ack", ea, ackOe)
		@(posedge clk);
		rdB <= 1'b1;
	endtask : rd

	// selected write pulse, start taken when the strobe rises
	task automatic wrp;
		@(posedge clk);
		csB <= 1'b0;
		wrB <= 1'b0;
		@(posedge clk);
		wrB <= 1'b1;
		@(posedge clk);
		csB <= 1'b1;
	endtask : wrp

	task automatic t_wr(input logic tc);
		logic [11:0] x;
		@(posedge clk);
		modeSel <= AHS_MODE_WR_UNGATED;
		twosComp <= tc;
		target <= 12'hA5C;
		x = 12'hA5C ^ {tc, 11'h000};
		wrp();
		wt(0, 1'b1);
		`CHK("ack busy", 1'b0, ackOe)
		repeat (6) @(negedge clk);
		rd(1'b1, {4'h0, x[11:8]}, 1'b0);
		wt(1, 1'b1);
		`CHK("running", 1'b0, convRunningInt)
		`CHK("dac code", 12'hA5C, dacCode)
		rd(1'b0, x[7:0], 1'b1);
		rd(1'b1, {4'h0, x[11:8]}, 1'b1);
		csB <= 1'b1;
	endtask : t_wr

	// unused select code must not convert
	task automatic t_off;
		@(posedge clk);
		modeSel <= 2'h0;
		wrp();
		repeat (4) @(negedge clk);
		`CHK("no start", 1'b0, convRunningInt)
		`CHK("ack pin", 1'b0, ackOut)
	endtask : t_off

	task automatic t_rd;
		@(posedge clk);
		modeSel <= AHS_MODE_RD_START;
		twosComp <= 1'b0;
		target <= 12'h3C7;
		@(posedge clk);
		csB <= 1'b0;
		@(posedge clk);
		rdB <= 1'b0;
		wt(0, 1'b1);
		@(negedge clk);
		`CHK("wait state", 1'b0, ackOe)
		wt(1, 1'b1);
		`CHK("low byte", 8'hC7, dataOut)
		`CHK("low valid", 1'b1, lowerValid)
		target <= 12'h6A1;
		@(posedge clk);
		rdB <= 1'b1;
		wt(0, 1'b1);
		`CHK("next start", 1'b1, convRunningInt)
		rd(1'b0, 8'h03, 1'b1);
		csB <= 1'b1;
		wt(0, 1'b0);
		repeat (4) @(negedge clk);
		`CHK("burst end", 1'b0, convRunningInt)
	endtask : t_rd

	// stand-alone ignores the output code select
	task automatic t_sa;
		@(posedge clk);
		standAlone <= 1'b1;
		twosComp <= 1'b1;
		target <= 12'hB18;
		@(posedge clk);
		wrB <= 1'b0;
		@(posedge clk);
		wrB <= 1'b1;
		wt(0, 1'b1);
		@(negedge clk);
		`CHK("sa busy", 1'b0, ackOe)
		repeat (4) @(negedge clk);
		`CHK("sa upper", 1'b1, upperValid)
		wt(1, 1'b1);
		rd(1'b1, 8'h0B, 1'b1);
		rd(1'b0, 8'h18, 1'b1);
	endtask : t_sa

	// reset for three clocks, then each scenario once, the write scenario with two's complement off and then on
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		t_wr(1'b0);
		t_wr(1'b1);
		t_off();
		t_rd();
		t_sa();
		close_out();
	end
endmodule : adc_host_mode_sequencer_tb
